// ---- iocec_counter.sv ----
// event selection and the two counters of the io coherency agent monitor
//
// The plain strobed port and the address map were decided locally.
`timescale 1ns/1ns
`default_nettype none
module iocec_counter (
    input  wire logic                 i_ref_clk,
    input  wire logic                 i_rst,
    input  wire logic                 i_clk_en,
    input  wire logic [4:0]           i_addr,
    input  wire logic [31:0]          i_wdata,
    input  wire logic                 i_wr,
    input  wire logic                 i_rd,
    input  wire iocec_pkg::iocec_ev_type i_ev,
    output logic      [31:0]          o_rdata,
    output logic                      o_rvalid
);

    // ==========================================================
    // helpers
    function automatic logic [3:0] ones(input logic [7:0] v);
        logic [3:0] s;
        s = 4'h0;
        for (int i = 0; i < 8; i++) begin
            s = s + {3'h0, v[i]};
        end
        return s;
    endfunction

    function automatic logic [6:0] w7(input logic [3:0] n);
        return {3'h0, n};
    endfunction

    // ==========================================================
    // event selection
    function automatic logic [6:0] inc_of(
        input iocec_pkg::iocec_ctl_type k,
        input iocec_pkg::iocec_ev_type  e
    );
        logic [7:0] m;
        logic       ok;
        logic [3:0] n;
        m  = k.umask;
        ok = 1'b0;
        n  = 4'h0;
        inc_of = 7'h00;
        case (k.code)
            iocec_pkg::EV_COH: begin
                inc_of = w7(ones(e.coh & m));
            end
            iocec_pkg::EV_TXN: begin
                // type bits summed, bit 7 only gates on source
                n = ones({2'h0, e.txn & m[5:0]});
                n = n + {3'h0, m[1] & e.txn_retry};
                ok = !m[7] || e.txn_src;
                if (ok) begin
                    inc_of = w7(n);
                end
            end
            iocec_pkg::EV_SNP: begin
                ok = (|(e.snp_resp & m[3:0])) && (|(e.snp_kind & m[6:4]));
                inc_of = {6'h00, ok};
            end
            iocec_pkg::EV_PEER_TXN: begin
                if (m[7:4] == 4'h0) begin
                    ok = 1'b1;
                end else begin
                    ok = (m[4] && e.peer_remote)
                      || (m[5] && e.peer_remote && e.peer_tgt)
                      || (m[6] && !e.peer_remote)
                      || (m[7] && !e.peer_remote && e.peer_tgt);
                end
                inc_of = {6'h00, ok && (|(e.peer_kind & m[3:0]))};
            end
            iocec_pkg::EV_PEER_REQ: begin
                inc_of = {6'h00, e.peer_req};
            end
            iocec_pkg::EV_PEER_OCC: begin
                inc_of = e.peer_occ;
            end
            iocec_pkg::EV_FAF_ALLOC: begin
                inc_of = {6'h00, e.faf_alloc};
            end
            iocec_pkg::EV_FAF_FULL: begin
                inc_of = {6'h00, e.faf_full};
            end
            iocec_pkg::EV_FAF_INS: begin
                inc_of = {6'h00, e.faf_ins};
            end
            iocec_pkg::EV_FAF_OCC: begin
                inc_of = e.faf_occ;
            end
            iocec_pkg::EV_MISC_EVENT_SET_ZERO: begin
                if (m[7:2] == 6'h00) begin
                    n = ones({6'h00, m[1:0] & {e.fast_rej, e.fast_req}});
                    inc_of = w7(n);
                end else if (m[1:0] == 2'h0 && m[6:5] == 2'h0) begin
                    n = ones({5'h00,
                              m[4:2] & {e.sec_at, e.sec_wr, e.sec_rd}});
                    inc_of = w7(n);
                end else if (m[4:0] == 5'h00 && !m[7]) begin
                    n = ones({6'h00, m[6:5] & {e.pf_ack, e.fast_xfer}});
                    inc_of = w7(n);
                end
            end
            iocec_pkg::EV_MISC_EVENT_SET_ONE: begin
                if (m[7:4] == 4'h0) begin
                    inc_of = w7(ones({4'h0, m[3:0] & e.slow}));
                end else if (m[3:0] == 4'h0) begin
                    // lost forward only with the upper bits clear
                    n = ones({5'h00, m[6:5] & {e.rcvd_vld, e.rcvd_invld},
                              m[4] && m[7:5] == 3'h0 && e.lost_forward});
                    inc_of = w7(n);
                end
            end
            iocec_pkg::EV_ALL: begin
                if (m == 8'h01) begin
                    inc_of = {6'h00, e.in_ins};
                end else if (m == 8'h02) begin
                    inc_of = {6'h00, e.out_ins};
                end
            end
            default: begin
                inc_of = 7'h00;
            end
        endcase
        if (!k.en) begin
            inc_of = 7'h00;
        end
    endfunction

    // ==========================================================
    // state
    iocec_pkg::iocec_state_type st_q;
    iocec_pkg::iocec_state_type st_d;

    always_comb begin
        st_d = st_q;
        st_d.rvalid = i_rd;
        st_d.rdata  = 32'h0000_0000;
        // each counter runs its own selection
        for (int c = 0; c < iocec_pkg::NCNT; c++) begin
            st_d.cnt[c] = st_q.cnt[c]
                + iocec_pkg::CNT_W'(inc_of(st_q.ctl[c], i_ev));
        end
        if (i_wr) begin
            if (i_addr == iocec_pkg::OFF_CTL0) begin
                st_d.ctl[0].code  = i_wdata[iocec_pkg::CTL_CODE_LSB +: 8];
                st_d.ctl[0].umask = i_wdata[iocec_pkg::CTL_MASK_LSB +: 8];
                st_d.ctl[0].en    = i_wdata[iocec_pkg::CTL_EN_BIT];
            end else if (i_addr == iocec_pkg::OFF_CTL1) begin
                st_d.ctl[1].code  = i_wdata[iocec_pkg::CTL_CODE_LSB +: 8];
                st_d.ctl[1].umask = i_wdata[iocec_pkg::CTL_MASK_LSB +: 8];
                st_d.ctl[1].en    = i_wdata[iocec_pkg::CTL_EN_BIT];
            end else if (i_addr == iocec_pkg::OFF_CNT0_LO) begin
                st_d.cnt[0][31:0] = i_wdata;
            end else if (i_addr == iocec_pkg::OFF_CNT0_HI) begin
                st_d.cnt[0][47:32] = i_wdata[15:0];
            end else if (i_addr == iocec_pkg::OFF_CNT1_LO) begin
                st_d.cnt[1][31:0] = i_wdata;
            end else if (i_addr == iocec_pkg::OFF_CNT1_HI) begin
                st_d.cnt[1][47:32] = i_wdata[15:0];
            end
        end
        if (i_rd) begin
            if (i_addr == iocec_pkg::OFF_CTL0) begin
                st_d.rdata = {9'h000, st_q.ctl[0].en, 6'h00,
                              st_q.ctl[0].umask, st_q.ctl[0].code};
            end else if (i_addr == iocec_pkg::OFF_CTL1) begin
                st_d.rdata = {9'h000, st_q.ctl[1].en, 6'h00,
                              st_q.ctl[1].umask, st_q.ctl[1].code};
            end else if (i_addr == iocec_pkg::OFF_CNT0_LO) begin
                st_d.rdata = st_q.cnt[0][31:0];
            end else if (i_addr == iocec_pkg::OFF_CNT0_HI) begin
                st_d.rdata = {16'h0000, st_q.cnt[0][47:32]};
            end else if (i_addr == iocec_pkg::OFF_CNT1_LO) begin
                st_d.rdata = st_q.cnt[1][31:0];
            end else if (i_addr == iocec_pkg::OFF_CNT1_HI) begin
                st_d.rdata = {16'h0000, st_q.cnt[1][47:32]};
            end
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            st_q.ctl    <= {iocec_pkg::NCNT{17'h0_0000}};
            st_q.cnt    <= {iocec_pkg::NCNT{iocec_pkg::CNT_RST}};
            st_q.rdata  <= iocec_pkg::CTL_RST;
            st_q.rvalid <= 1'b0;
        end else if (i_clk_en) begin
            st_q <= st_d;
        end
    end

    assign o_rdata  = st_q.rdata;
    assign o_rvalid = st_q.rvalid;

    // ==========================================================
    // checks on counter zero
    logic [47:0]               c0;
    iocec_pkg::iocec_ctl_type  k0;
    logic                      quiet0;
    assign c0 = st_q.cnt[0];
    assign k0 = st_q.ctl[0];
    assign quiet0 = i_clk_en && !(i_wr
        && (i_addr == iocec_pkg::OFF_CNT0_LO
         || i_addr == iocec_pkg::OFF_CNT0_HI));

    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_rst);

    sequence s_cfg(logic [7:0] c, logic [7:0] m);
        quiet0 && k0.en && k0.code == c && k0.umask == m;
    endsequence

    sequence s_ctl_write;
        i_clk_en && i_wr && i_addr == iocec_pkg::OFF_CTL0;
    endsequence

    sequence s_ctl_read;
        i_clk_en && i_rd && !i_wr && i_addr == iocec_pkg::OFF_CTL0;
    endsequence

    a_coh_flush: assert property (
        s_cfg(8'h10, 8'h80) ##0 i_ev.coh[7]
        |=> c0 == $past(c0) + 48'h0000_0000_0001)
        else $error("flush request not counted once");

    a_all_inbound: assert property (
        s_cfg(8'h1e, 8'h01) ##0 (i_ev.in_ins && !i_ev.out_ins)
        |=> c0 == $past(c0) + 48'h0000_0000_0001)
        else $error("inbound insert not counted");

    a_fast_reject: assert property (
        s_cfg(8'h1c, 8'h02) ##0 (i_ev.fast_rej && !i_ev.fast_req)
        |=> c0 == $past(c0) + 48'h0000_0000_0001)
        else $error("fastpath reject not counted");

    a_sec_read: assert property (
        s_cfg(8'h1c, 8'h04) ##0 i_ev.sec_rd
        |=> c0 == $past(c0) + 48'h0000_0000_0001)
        else $error("secondary read insert not counted");

    a_lost_forward: assert property (
        s_cfg(8'h1d, 8'h10) ##0 !i_ev.lost_forward
        |=> c0 == $past(c0))
        else $error("lost forward counted without event");

    a_peer_occ: assert property (
        s_cfg(8'h15, 8'h00)
        |=> c0 == $past(c0) + {41'h0, $past(i_ev.peer_occ)})
        else $error("peer occupancy not accumulated");

    a_snoop_groups: assert property (
        quiet0 && k0.code == 8'h12
        && (k0.umask[3:0] == 4'h0 || k0.umask[6:4] == 3'h0)
        |=> c0 == $past(c0))
        else $error("snoop response counted with empty group");

    a_txn_source: assert property (
        s_cfg(8'h11, 8'h81) ##0 !i_ev.txn_src
        |=> c0 == $past(c0))
        else $error("inbound read counted without source match");

    a_write_retry: assert property (
        s_cfg(8'h11, 8'h02) ##0 (i_ev.txn[1] && i_ev.txn_retry)
        |=> c0 == $past(c0) + 48'h0000_0000_0002)
        else $error("write retry not counted extra");

    a_unsupported: assert property (
        quiet0 && (k0.code < 8'h10 || k0.code > 8'h1e
                   || k0.code == 8'h1a || k0.code == 8'h1b)
        |=> c0 == $past(c0))
        else $error("unsupported code changed counter");

    a_ctl_readback: assert property (
        s_ctl_write ##1 s_ctl_read
        |=> o_rvalid && o_rdata[15:0] == $past(i_wdata[15:0], 2))
        else $error("control register read back wrong");

endmodule
`default_nettype wire

// ---- iocec_pipe_model.sv ----
// coherency pipeline model feeding per-cycle event indications
`timescale 1ns/1ns
`default_nettype none
module iocec_pipe_model (
    input  wire logic                    i_ref_clk,
    input  wire logic                    i_run,
    output var  iocec_pkg::iocec_ev_type o_ev
);
    // ==========================================================
    // event source
    logic [95:0] rnd;

    // random pulses and levels while running, quiet otherwise
    always @(posedge i_ref_clk) begin
        rnd = {$urandom, $urandom, $urandom};
        if (i_run) begin
            o_ev <= rnd[$bits(iocec_pkg::iocec_ev_type)-1:0];
        end else begin
            o_ev <= '0;
        end
    end
endmodule
`default_nettype wire

// ---- iocec_pkg.sv ----
// constants, types and field layouts of the io coherency event counter
//
// Functional notes
// - code 0x10 counts coherency operations, one mask bit per request type.
// - code 0x1e mask 0x01 counts inbound inserts, mask 0x02 outbound inserts.
// - code 0x1c mask bit 0 counts fastpath requests, bit 1 fastpath rejects.
// - misc set zero counts secondary inserts of reads, writes and atomics.
// - misc set zero counts fastpath transfers and prefetch ack hints.
// - code 0x1d low four mask bits count slow transfers of I, S, E, M lines.
// - misc set one mask bit 4 alone counts lost forwards.
// - misc set one bits 5 and 6 count transfers without and with enough state.
// - code 0x14 counts peer requests from the inbound transaction controller.
// - code 0x15 adds peer queue occupancy every cycle.
// - code 0x13 bits 0-3 pick peer kinds; bits 4, 5 qualify remote traffic.
// - peer transactions bits 6, 7 qualify local traffic and local target match.
// - snoop responses count only with one response bit and one snoop bit.
// - code 0x11 counts inbound transactions passed to the uncore.
// - inbound transaction type bits add up, one count per set type bit.
// - with the source bit set, a source port match is also required.
// - inbound mask bit 7 is only a qualifier and counts nothing alone.
// - inbound reads count read requests and never read prefetches.
// - inbound writes count requests plus one for every write retry.
// - inbound bits 2 and 3 count read and write prefetches.
// - inbound bits 4 and 5 count atomic and other transactions.
// - fast-allocate events use codes 0x16, 0x17, 0x18 and 0x19.
// - two 48-bit counters, each able to count any event.
package iocec_pkg;

    localparam int CNT_W = 48;
    localparam int NCNT  = 2;
    localparam int INC_W = 7;
    localparam int ADR_W = 5;

    // register offsets
    localparam logic [ADR_W-1:0] OFF_CTL0    = 5'h00;
    localparam logic [ADR_W-1:0] OFF_CTL1    = 5'h04;
    localparam logic [ADR_W-1:0] OFF_CNT0_LO = 5'h08;
    localparam logic [ADR_W-1:0] OFF_CNT0_HI = 5'h0c;
    localparam logic [ADR_W-1:0] OFF_CNT1_LO = 5'h10;
    localparam logic [ADR_W-1:0] OFF_CNT1_HI = 5'h14;

    // control register field positions and reset values
    localparam int CTL_CODE_LSB = 0;
    localparam int CTL_MASK_LSB = 8;
    localparam int CTL_EN_BIT   = 22;
    localparam logic [31:0] CTL_RST = 32'h0000_0000;
    localparam logic [CNT_W-1:0] CNT_RST = 48'h0000_0000_0000;

    // event codes
    localparam logic [7:0] EV_COH       = 8'h10;
    localparam logic [7:0] EV_TXN       = 8'h11;
    localparam logic [7:0] EV_SNP       = 8'h12;
    localparam logic [7:0] EV_PEER_TXN  = 8'h13;
    localparam logic [7:0] EV_PEER_REQ  = 8'h14;
    localparam logic [7:0] EV_PEER_OCC  = 8'h15;
    localparam logic [7:0] EV_FAF_ALLOC = 8'h16;
    localparam logic [7:0] EV_FAF_FULL  = 8'h17;
    localparam logic [7:0] EV_FAF_INS   = 8'h18;
    localparam logic [7:0] EV_FAF_OCC   = 8'h19;
    localparam logic [7:0] EV_MISC_EVENT_SET_ZERO     = 8'h1c;
    localparam logic [7:0] EV_MISC_EVENT_SET_ONE     = 8'h1d;
    localparam logic [7:0] EV_ALL       = 8'h1e;

    typedef struct packed {
        logic                en;
        logic [7:0]          umask;
        logic [7:0]          code;
    } iocec_ctl_type;

    // per-cycle indications from the coherency pipeline
    typedef struct packed {
        logic [7:0]          coh;
        logic                in_ins;
        logic                out_ins;
        logic                fast_req;
        logic                fast_rej;
        logic                sec_rd;
        logic                sec_wr;
        logic                sec_at;
        logic                fast_xfer;
        logic                pf_ack;
        logic [3:0]          slow;
        logic                lost_forward;
        logic                rcvd_invld;
        logic                rcvd_vld;
        logic                peer_req;
        logic [INC_W-1:0]    peer_occ;
        logic [3:0]          peer_kind;
        logic                peer_remote;
        logic                peer_tgt;
        logic [3:0]          snp_resp;
        logic [2:0]          snp_kind;
        logic [5:0]          txn;
        logic                txn_retry;
        logic                txn_src;
        logic                faf_alloc;
        logic                faf_full;
        logic                faf_ins;
        logic [INC_W-1:0]    faf_occ;
    } iocec_ev_type;

    typedef struct packed {
        iocec_ctl_type [NCNT-1:0]           ctl;
        logic [NCNT-1:0][CNT_W-1:0]         cnt;
        logic [31:0]                        rdata;
        logic                               rvalid;
    } iocec_state_type;

endpackage

// ---- tb_io_coherency_event_counter.sv ----
// self-checking testbench of the io coherency event counter
`timescale 1ns/1ns
`default_nettype none
module tb_io_coherency_event_counter;
    logic                           i_ref_clk;
    logic                           i_rst;
    logic                           i_clk_en;
    logic                           i_wr;
    logic                           i_rd;
    logic                           run;
    logic [4:0]                     i_addr;
    logic [31:0]                    i_wdata;
    logic [31:0]                    o_rdata;
    logic                           o_rvalid;
    iocec_pkg::iocec_ev_type        ev;
    iocec_pkg::iocec_ctl_type [1:0] mctl;
    logic [1:0][47:0]               mcnt;
    logic [31:0]                    expq[$];
    logic [16:0]                    tab[40];
    int                             fails;
    int                             n_compared;
    int                             cycles;

    iocec_counter i_dut (
        .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_clk_en(i_clk_en),
        .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
        .i_ev(ev), .o_rdata(o_rdata), .o_rvalid(o_rvalid)
    );
    iocec_pipe_model i_pipe (.i_ref_clk(i_ref_clk), .i_run(run), .o_ev(ev));

    // ==========================================================
    // reference increment
    function automatic int unsigned inc_of(iocec_pkg::iocec_ctl_type k,
                                           iocec_pkg::iocec_ev_type e);
        logic [7:0] m;
        logic       r;
        logic       lc;
        m = k.umask;
        r = e.peer_remote;
        lc = (m[7:4] == 4'h0) || (m[4] && r) || (m[5] && r && e.peer_tgt)
            || (m[6] && !r) || (m[7] && !r && e.peer_tgt);
        if (!k.en) return 0;
        case (k.code)
            iocec_pkg::EV_COH:       return $countones(e.coh & m);
            iocec_pkg::EV_TXN:       return (m[7] && !e.txn_src) ? 0 :
                $countones(e.txn & m[5:0]) + int'(m[1] & e.txn_retry);
            iocec_pkg::EV_SNP:       return int'((|(e.snp_resp & m[3:0]))
                && (|(e.snp_kind & m[6:4])));
            iocec_pkg::EV_PEER_TXN:  return int'((|(e.peer_kind & m[3:0]))
                && lc);
            iocec_pkg::EV_PEER_REQ:  return int'(e.peer_req);
            iocec_pkg::EV_PEER_OCC:  return int'(e.peer_occ);
            iocec_pkg::EV_FAF_ALLOC: return int'(e.faf_alloc);
            iocec_pkg::EV_FAF_FULL:  return int'(e.faf_full);
            iocec_pkg::EV_FAF_INS:   return int'(e.faf_ins);
            iocec_pkg::EV_FAF_OCC:   return int'(e.faf_occ);
            iocec_pkg::EV_MISC_EVENT_SET_ZERO: begin
                if (m[7:2] == 6'h00)
                    return $countones({e.fast_rej, e.fast_req} & m[1:0]);
                if (m[1:0] == 2'h0 && m[6:5] == 2'h0)
                    return $countones({e.sec_at, e.sec_wr, e.sec_rd} & m[4:2]);
                if (m[4:0] == 5'h00 && !m[7])
                    return $countones({e.pf_ack, e.fast_xfer} & m[6:5]);
            end
            iocec_pkg::EV_MISC_EVENT_SET_ONE: begin
                if (m[7:4] == 4'h0) return $countones(e.slow & m[3:0]);
                if (m[3:0] == 4'h0)
                    return $countones({e.rcvd_vld, e.rcvd_invld} & m[6:5])
                        + int'(m[7:5] == 3'h0 && m[4] && e.lost_forward);
            end
            iocec_pkg::EV_ALL: begin
                if (m == 8'h01) return int'(e.in_ins);
                if (m == 8'h02) return int'(e.out_ins);
            end
            default: return 0;
        endcase
        return 0;
    endfunction

    function automatic logic [31:0] exp_of(logic [4:0] a);
        case (a)
            iocec_pkg::OFF_CTL0, iocec_pkg::OFF_CTL1: return {9'h000,
                mctl[a[2]].en, 6'h00, mctl[a[2]].umask, mctl[a[2]].code};
            iocec_pkg::OFF_CNT0_LO, iocec_pkg::OFF_CNT1_LO:
                return mcnt[a[4]][31:0];
            iocec_pkg::OFF_CNT0_HI, iocec_pkg::OFF_CNT1_HI:
                return {16'h0000, mcnt[a[4]][47:32]};
            default: return 32'h0000_0000;
        endcase
    endfunction

    // ==========================================================
    // bus tasks and report
    task automatic op(input logic w, input logic [4:0] a,
                      input logic [31:0] d);
        @(posedge i_ref_clk);
        i_clk_en <= 1'b1;
        i_wr     <= w;
        i_rd     <= !w;
        i_addr   <= a;
        i_wdata  <= d;
        if (!w) expq.push_back(exp_of(a));
    endtask

    task automatic wrt(input logic [4:0] a, input logic [31:0] d);
        op(1'b1, a, d);
        if (a == 5'h00 || a == 5'h04) mctl[a[2]] = {d[22], d[15:8], d[7:0]};
        else if (a >= 5'h08 && a <= 5'h14 && !a[2]) mcnt[a[4]][31:0] = d;
        else if (a >= 5'h08 && a <= 5'h14) mcnt[a[4]][47:32] = d[15:0];
    endtask

    task automatic rd_all();
        for (int a = 0; a < 32; a += 4) op(1'b0, 5'(a), 32'h0000_0000);
        @(posedge i_ref_clk);
        i_rd <= 1'b0;
    endtask

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("unexpected read data at %0t: got %h expected %h",
                     $time, got, exp);
        end
    endtask

    task automatic conclude();
        if (expq.size() != 0) fails++;
        if (fails == 0 && n_compared > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    // ==========================================================
    // clock, model tracking and monitor
    initial begin
        i_ref_clk = 1'b0;
        forever #5 i_ref_clk = ~i_ref_clk;
    end

    always @(posedge i_ref_clk) begin
        cycles++;
        if (cycles > 5000) begin
            fails++;
            conclude();
        end else begin
            if (i_rst) begin
                mctl = '0;
                mcnt = '0;
            end else if (i_clk_en) begin
                for (int c = 0; c < 2; c++)
                    mcnt[c] = mcnt[c] + 48'(inc_of(mctl[c], ev));
            end
            if (o_rvalid === 1'b1) begin
                if (expq.size() == 0) cmp(o_rdata, 32'hffff_ffff);
                else cmp(o_rdata, expq.pop_front());
            end
        end
    end

    // ==========================================================
    // stimulus
    initial begin
        tab = '{17'h1_8010, 17'h1_ff10,
            17'h1_0211, 17'h1_8011, 17'h1_8111, 17'h1_3f11,
            17'h1_0511, 17'h1_c211,
            17'h1_0f12, 17'h1_1112, 17'h1_7f12, 17'h1_4812,
            17'h1_0f13, 17'h1_1f13, 17'h1_2a13,
            17'h1_c513, 17'h1_4113,
            17'h1_0014, 17'h1_0015,
            17'h1_0016, 17'h1_0017, 17'h1_0018, 17'h1_0019,
            17'h1_031c, 17'h1_1c1c,
            17'h1_601c, 17'h1_801c,
            17'h1_0f1d, 17'h1_101d,
            17'h1_701d, 17'h1_301d,
            17'h1_021e, 17'h1_011e, 17'h1_031e,
            17'h1_021c, 17'h1_081c,
            17'h1_041c, 17'h1_101c,
            17'h1_001a, 17'h0_ff10};
        i_rst = 1'b1;
        i_clk_en = 1'b1;
        i_wr = 1'b0;
        i_rd = 1'b0;
        i_addr = 5'h00;
        i_wdata = 32'h0000_0000;
        run = 1'b0;
        fails = 0;
        n_compared = 0;
        cycles = 0;
        mctl = '0;
        mcnt = '0;
        void'($urandom(93783));
        repeat (5) @(posedge i_ref_clk);
        i_rst <= 1'b0;
        rd_all();
        wrt(5'h18, $urandom);
        wrt(5'h1c, $urandom);
        @(posedge i_ref_clk);
        i_clk_en <= 1'b0;
        i_wr <= 1'b1;
        i_addr <= 5'h00;
        i_wdata <= 32'h0040_ff10;
        rd_all();
        for (int p = 0; p < 40; p += 2) begin
            for (int c = 0; c < 2; c++) begin
                wrt(5'(c * 4), {9'h000, tab[p + c][16], 6'h00,
                    tab[p + c][15:0]} | ($urandom & 32'hffbf_0000));
                op(1'b0, 5'(c * 4), 32'h0000_0000);
                wrt(5'(8 + c * 8), $urandom | 32'hffff_f000);
                wrt(5'(12 + c * 8), $urandom);
            end
            @(posedge i_ref_clk);
            i_wr <= 1'b0;
            i_rd <= 1'b0;
            run <= 1'b1;
            repeat (40) begin
                @(posedge i_ref_clk);
                i_clk_en <= ($urandom % 4) != 0;
            end
            @(posedge i_ref_clk);
            run <= 1'b0;
            i_clk_en <= 1'b1;
            repeat (3) @(posedge i_ref_clk);
            rd_all();
        end
        run <= 1'b1;
        repeat (10) @(posedge i_ref_clk);
        i_rst <= 1'b1;
        repeat (2) @(posedge i_ref_clk);
        i_rst <= 1'b0;
        run <= 1'b0;
        repeat (3) @(posedge i_ref_clk);
        rd_all();
        repeat (3) @(posedge i_ref_clk);
        conclude();
    end
endmodule
`default_nettype wire
